// *** rtl/sbp_pkg.sv ***
// Package for the asynchronous serial block: register map, field positions, reset values, carriers.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package sbp_pkg;
	localparam logic [7:0] SBP_OFS_STATUS = 8'h00;
	localparam logic [7:0] SBP_OFS_DATA = 8'h04;
	localparam logic [7:0] SBP_OFS_CTRL1 = 8'h08;
	localparam logic [7:0] SBP_OFS_CTRL2 = 8'h0c;
	localparam logic [7:0] SBP_OFS_BAUD = 8'h10;
	localparam logic [7:0] SBP_OFS_RXFINE = 8'h14;
	localparam logic [7:0] SBP_OFS_TXFINE = 8'h18;
	localparam logic [7:0] SBP_OFS_MISC = 8'h1c;
	localparam logic [7:0] SBP_STATUS_RST = 8'hc0;
	localparam logic [7:0] SBP_CTRL_RST = 8'h00;
	localparam int SBP_OVERSAMPLE = 16;
	localparam int SBP_MID_SAMPLE = 8;
	localparam int SBP_BIT_TX_EMPTY = 7;
	localparam int SBP_BIT_TX_DONE = 6;
	localparam int SBP_BIT_RX_FULL = 5;
	localparam int SBP_BIT_QUIET = 4;
	localparam int SBP_BIT_OVERRUN = 3;
	localparam int SBP_BIT_NOISE = 2;
	localparam int SBP_BIT_FRAME = 1;
	localparam int SBP_BIT_PARITY = 0;
	typedef struct packed {
		logic rx_ninth_bit;
		logic tx_ninth_bit;
		logic low_power_off;
		logic nine_bit_word;
		logic rouse_method_select;
		logic parity_enable;
		logic parity_odd_select;
		logic parity_irq_en;
	} sbp_ctrl1_type;
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_irq_en;
		logic quiet_line_irq_en;
		logic tx_enable;
		logic rx_enable;
		logic mute_select;
		logic send_break;
	} sbp_ctrl2_type;
	typedef struct packed {
		logic [1:0] base_prescale_field;
		logic [2:0] tx_divisor_field;
		logic [2:0] rx_divisor_field;
	} sbp_baud_type;
endpackage

// *** rtl/sbp_serial.sv ***
// Asynchronous serial interface with baud generators, mute/wake-up and parity, behind an APB slave.
// Assumes pclk drives everything and the rx pin is already synchronous to it.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module sbp_serial import sbp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_pin,
	input wire logic cpu_irq_mask,
	output logic tx_pin,
	output logic irq
);
	typedef enum {SBP_TX_IDLE, SBP_TX_PREAMBLE, SBP_TX_FRAME} sbp_tx_state_type;

	function automatic logic [3:0] sbp_base_div(input logic [1:0] sel);
		case (sel)
			2'h0: sbp_base_div = 4'h0;
			2'h1: sbp_base_div = 4'h2;
			2'h2: sbp_base_div = 4'h3;
			default: sbp_base_div = 4'hc;
		endcase
	endfunction

	// Even-count-of-ones parity, inverted for odd
	function automatic logic sbp_parity(input logic [8:0] d, input logic nine, input logic odd);
		sbp_parity = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
	endfunction

	sbp_ctrl1_type ctrl1;
	sbp_ctrl2_type ctrl2;
	sbp_baud_type baud;
	logic [7:0] rx_fine_prescaler;
	logic [7:0] tx_fine_prescaler;
	logic [7:0] status;
	logic [7:0] rx_holding_buffer;
	logic [8:0] tx_holding_buffer;
	logic clear_armed;
	logic quiet_armed;

	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic rd = acc && !pwrite;
	wire logic hit_status = paddr == SBP_OFS_STATUS;
	wire logic hit_data = paddr == SBP_OFS_DATA;
	wire logic mapped = paddr inside {SBP_OFS_STATUS, SBP_OFS_DATA, SBP_OFS_CTRL1, SBP_OFS_CTRL2,
		SBP_OFS_BAUD, SBP_OFS_RXFINE, SBP_OFS_TXFINE};
	wire logic data_wr_clear = wr && hit_data && clear_armed;
	wire logic data_rd_clear = rd && hit_data && clear_armed;
	wire logic data_any_clear = acc && hit_data && clear_armed;

	// Separate per-direction baud ticks from base, power-of-two and fine stages; the tx fine stage comes after its x16 stage
	logic [3:0] tx_base_cnt, rx_base_cnt;
	logic [6:0] tx_pow_cnt, rx_pow_cnt;
	logic [7:0] tx_fine_cnt, rx_fine_cnt;
	wire logic run = !ctrl1.low_power_off;
	wire logic [6:0] tx_pow_max = 7'((8'h1 << baud.tx_divisor_field) - 8'h1);
	wire logic [6:0] rx_pow_max = 7'((8'h1 << baud.rx_divisor_field) - 8'h1);
	wire logic tx_base_end = tx_base_cnt == sbp_base_div(baud.base_prescale_field);
	wire logic rx_base_end = rx_base_cnt == sbp_base_div(baud.base_prescale_field);
	wire logic tx_pow_end = tx_base_end && tx_pow_cnt == tx_pow_max;
	wire logic rx_pow_end = rx_base_end && rx_pow_cnt == rx_pow_max;
	// Zero fine value bypasses the extended stage; the tx x16 stage is the tx_sub counter below, the rx one is the receiver's rx_os bit counter
	wire logic tx_fine_end = tx_fine_prescaler == 8'h00 || tx_fine_cnt == tx_fine_prescaler - 8'h01;
	wire logic rx_fine_end = rx_fine_prescaler == 8'h00 || rx_fine_cnt == rx_fine_prescaler - 8'h01;
	// Fine stage counts 16-tick groups so it divides after the /16 stage
	logic [3:0] tx_sub;
	wire logic tx_sub_end = tx_pow_end && tx_sub == 4'hf;
	// Receive ticks already run at 16 per bit, so no group counter is needed there
	wire logic tx_bit_tick = tx_sub_end && tx_fine_end;
	wire logic rx_os_tick = rx_pow_end && rx_fine_end;
	sbp_tx_state_type tx_state;
	logic rx_busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_base_cnt <= 4'h0;
			tx_pow_cnt <= 7'h0;
			tx_sub <= 4'h0;
			tx_fine_cnt <= 8'h00;
		end else if (run || tx_state != SBP_TX_IDLE) begin
			tx_base_cnt <= tx_base_end ? 4'h0 : tx_base_cnt + 4'h1;
			if (tx_base_end)
				tx_pow_cnt <= tx_pow_end ? 7'h0 : tx_pow_cnt + 7'h1;
			if (tx_pow_end)
				tx_sub <= tx_sub + 4'h1;
			if (tx_sub_end)
				tx_fine_cnt <= tx_fine_end ? 8'h00 : tx_fine_cnt + 8'h01;
		end
	end

	// Receiver oversamples at 16 per bit; the fine stage there repeats each sample slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_base_cnt <= 4'h0;
			rx_pow_cnt <= 7'h0;
			rx_fine_cnt <= 8'h00;
		end else if (run || rx_busy) begin
			rx_base_cnt <= rx_base_end ? 4'h0 : rx_base_cnt + 4'h1;
			if (rx_base_end)
				rx_pow_cnt <= rx_pow_end ? 7'h0 : rx_pow_cnt + 7'h1;
			if (rx_pow_end)
				rx_fine_cnt <= rx_fine_end ? 8'h00 : rx_fine_cnt + 8'h01;
		end
	end

	// Transmitter
	logic [10:0] tx_shift;
	logic [3:0] tx_bits;
	logic tx_pending;
	logic tx_en_q;
	wire logic [3:0] frame_bits = ctrl1.nine_bit_word ? 4'hb : 4'ha;
	wire logic [8:0] tx_word = {ctrl1.tx_ninth_bit, tx_holding_buffer[7:0]};
	wire logic tx_msb_par = sbp_parity(tx_word, ctrl1.nine_bit_word, ctrl1.parity_odd_select);
	wire logic [8:0] tx_final = !ctrl1.parity_enable ? tx_word :
		ctrl1.nine_bit_word ? {tx_msb_par, tx_word[7:0]} : {1'b0, tx_msb_par, tx_word[6:0]};
	wire logic [10:0] tx_load = ctrl1.nine_bit_word ? {1'b1, tx_final, 1'b0} : {2'b11, tx_final[7:0], 1'b0};
	wire logic frame_end = tx_bit_tick && tx_bits == 4'h1;
	wire logic tx_take = tx_state == SBP_TX_IDLE && ctrl2.tx_enable && run &&
		(tx_pending || ctrl2.send_break);
	wire logic tx_data_move = tx_take && !ctrl2.send_break;
	wire logic tx_frame_done = frame_end && tx_state != SBP_TX_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= SBP_TX_IDLE;
			tx_shift <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_en_q <= 1'b0;
			tx_pin <= 1'b1;
		end else begin
			tx_en_q <= ctrl2.tx_enable;
			case (tx_state)
				SBP_TX_IDLE: begin
					if (ctrl2.tx_enable && !tx_en_q) begin
						tx_state <= SBP_TX_PREAMBLE;
						tx_shift <= 11'h7ff;
						tx_bits <= frame_bits;
					end else if (tx_take) begin
						tx_state <= SBP_TX_FRAME;
						tx_shift <= ctrl2.send_break ? 11'h000 : tx_load;
						tx_bits <= frame_bits;
					end
				end
				SBP_TX_PREAMBLE, SBP_TX_FRAME: begin
					if (tx_bit_tick) begin
						tx_pin <= tx_shift[0];
						tx_shift <= {1'b1, tx_shift[10:1]};
						tx_bits <= tx_bits - 4'h1;
						if (tx_bits == 4'h1)
							tx_state <= SBP_TX_IDLE;
					end
				end
				default: tx_state <= SBP_TX_IDLE;
			endcase
			if (tx_state == SBP_TX_IDLE && tx_bit_tick)
				tx_pin <= 1'b1;
		end
	end

	// Receiver: mid-bit sampling with majority of three for noise
	logic [3:0] rx_os;
	logic [3:0] rx_bitno;
	logic [9:0] rx_shift;
	logic [2:0] rx_maj;
	logic rx_noise;
	logic [3:0] rx_ones;
	logic rx_pin_q;
	wire logic maj = (rx_maj[0] & rx_maj[1]) | (rx_maj[1] & rx_maj[2]) | (rx_maj[0] & rx_maj[2]);
	wire logic maj_noisy = !(&rx_maj) && |rx_maj;
	wire logic rx_end = rx_busy && rx_os_tick && rx_os == 4'hf && rx_bitno == frame_bits - 4'h1;
	wire logic [8:0] rx_data = ctrl1.nine_bit_word ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
	wire logic rx_msb = ctrl1.nine_bit_word ? rx_data[8] : rx_data[7];
	// Received MSB must equal the parity that the transmitter would have sent
	wire logic par_bad = ctrl1.parity_enable &&
		sbp_parity(rx_data, ctrl1.nine_bit_word, ctrl1.parity_odd_select) != rx_msb;
	// One recognition per idle stretch, so a line left idle cannot wake a later mute at once
	wire logic idle_seen = ctrl2.rx_enable && !rx_busy && rx_os_tick && rx_os == 4'hf && rx_pin &&
		rx_ones == frame_bits - 4'h1;
	wire logic muted = ctrl2.mute_select;
	wire logic addr_wake = muted && ctrl1.rouse_method_select && rx_end && rx_msb;
	wire logic idle_wake = muted && !ctrl1.rouse_method_select && idle_seen;
	wire logic rx_accept = ctrl2.rx_enable && rx_end && (!muted || addr_wake);
	wire logic rx_move = rx_accept && !status[SBP_BIT_RX_FULL];
	wire logic rx_over = rx_accept && status[SBP_BIT_RX_FULL];
	wire logic frame_bad = !maj;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy <= 1'b0;
			rx_os <= 4'h0;
			rx_bitno <= 4'h0;
			rx_shift <= 10'h000;
			rx_maj <= 3'h7;
			rx_noise <= 1'b0;
			rx_ones <= 4'h0;
			rx_pin_q <= 1'b1;
		end else if (!ctrl2.rx_enable) begin
			rx_busy <= 1'b0;
			rx_ones <= 4'h0;
		end else if (rx_os_tick) begin
			rx_pin_q <= rx_pin;
			rx_os <= rx_os + 4'h1;
			if (rx_os >= SBP_MID_SAMPLE - 1 && rx_os <= SBP_MID_SAMPLE + 1)
				rx_maj <= {rx_maj[1:0], rx_pin};
			if (!rx_busy) begin
				if (rx_pin_q && !rx_pin && run) begin
					rx_busy <= 1'b1;
					rx_os <= 4'h1;
					rx_bitno <= 4'h0;
					rx_noise <= 1'b0;
				end else if (rx_os == 4'hf) begin
					rx_ones <= !rx_pin ? 4'h0 : (rx_ones == frame_bits ? rx_ones : rx_ones + 4'h1);
				end
			end else if (rx_os == 4'hf) begin
				rx_shift <= {maj, rx_shift[9:1]};
				rx_noise <= rx_noise | maj_noisy;
				rx_bitno <= rx_bitno + 4'h1;
				if (rx_bitno == frame_bits - 4'h1) begin
					rx_busy <= 1'b0;
					rx_ones <= 4'h0;
				end
			end
		end
	end

	// Status flags: hardware set wins over the software clear sequence
	logic [7:0] next_status;
	always_comb begin
		next_status = status;
		if (data_wr_clear) begin
			next_status[SBP_BIT_TX_EMPTY] = 1'b0;
			next_status[SBP_BIT_TX_DONE] = 1'b0;
		end
		if (data_rd_clear)
			next_status[5:1] = 5'h00;
		if (data_any_clear)
			next_status[SBP_BIT_PARITY] = 1'b0;
		if (tx_data_move)
			next_status[SBP_BIT_TX_EMPTY] = 1'b1;
		if (tx_frame_done)
			next_status[SBP_BIT_TX_DONE] = 1'b1;
		if (rx_move) begin
			next_status[SBP_BIT_RX_FULL] = 1'b1;
			next_status[SBP_BIT_NOISE] = rx_noise;
			next_status[SBP_BIT_FRAME] = frame_bad;
			if (par_bad)
				next_status[SBP_BIT_PARITY] = 1'b1;
		end
		if (rx_over)
			next_status[SBP_BIT_OVERRUN] = 1'b1;
		if (idle_seen && quiet_armed && !muted && ctrl2.rx_enable)
			next_status[SBP_BIT_QUIET] = 1'b1;
		if (!ctrl2.rx_enable)
			next_status[5:1] = 5'h00;
	end

	wire logic [7:0] ctrl1_rd = ctrl1;
	wire logic [31:0] rd_mux =
		hit_status ? {24'h0, status} :
		hit_data ? {24'h0, rx_holding_buffer} :
		paddr == SBP_OFS_CTRL1 ? {24'h0, ctrl1_rd} :
		paddr == SBP_OFS_CTRL2 ? {24'h0, ctrl2} :
		paddr == SBP_OFS_BAUD ? {24'h0, baud} :
		paddr == SBP_OFS_RXFINE ? {24'h0, rx_fine_prescaler} :
		paddr == SBP_OFS_TXFINE ? {24'h0, tx_fine_prescaler} : 32'h0;
	// level request, gated by each enable and the CPU mask
	wire logic next_irq = !cpu_irq_mask && (
		(ctrl2.tx_empty_irq_en && next_status[SBP_BIT_TX_EMPTY]) ||
		(ctrl2.tx_done_irq_en && next_status[SBP_BIT_TX_DONE]) ||
		(ctrl2.rx_irq_en && (next_status[SBP_BIT_RX_FULL] || next_status[SBP_BIT_OVERRUN])) ||
		(ctrl2.quiet_line_irq_en && next_status[SBP_BIT_QUIET]) ||
		(ctrl1.parity_irq_en && next_status[SBP_BIT_PARITY]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= SBP_STATUS_RST;
			ctrl1 <= SBP_CTRL_RST;
			ctrl2 <= SBP_CTRL_RST;
			baud <= SBP_CTRL_RST;
			rx_fine_prescaler <= 8'h00;
			tx_fine_prescaler <= 8'h00;
			rx_holding_buffer <= 8'h00;
			tx_holding_buffer <= 9'h000;
			tx_pending <= 1'b0;
			clear_armed <= 1'b0;
			quiet_armed <= 1'b1;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= next_irq;
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
			if (rd && hit_status)
				clear_armed <= 1'b1;
			else if (acc && hit_data)
				clear_armed <= 1'b0;
			if (rx_move && ctrl1.nine_bit_word && !muted)
				ctrl1.rx_ninth_bit <= rx_data[8];
			if (rx_move)
				rx_holding_buffer <= rx_data[7:0];
			if (rx_move)
				quiet_armed <= 1'b1;
			else if (next_status[SBP_BIT_QUIET])
				quiet_armed <= 1'b0;
			if (addr_wake || idle_wake)
				ctrl2.mute_select <= 1'b0;
			if (tx_data_move)
				tx_pending <= 1'b0;
			if (wr) begin
				if (hit_data) begin
					tx_holding_buffer <= {1'b0, pwdata[7:0]};
					tx_pending <= 1'b1;
				end
				if (paddr == SBP_OFS_CTRL1)
					ctrl1[6:0] <= pwdata[6:0];
				if (paddr == SBP_OFS_CTRL2)
					ctrl2 <= pwdata[7:0];
				// no interlock: software must not change these while enabled
				if (paddr == SBP_OFS_BAUD)
					baud <= pwdata[7:0];
				if (paddr == SBP_OFS_RXFINE)
					rx_fine_prescaler <= pwdata[7:0];
				if (paddr == SBP_OFS_TXFINE)
					tx_fine_prescaler <= pwdata[7:0];
			end
		end
	end
endmodule // sbp_serial

// *** bench/sbp_serial_props.sv ***
// Concurrent checks on the serial block's APB answers, interrupt gating and transmit line.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module sbp_serial_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_pin,
	input wire logic cpu_irq_mask,
	input wire logic tx_pin,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr)
		else $error("no error for unmapped address");
	a_err_mapped: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("error on mapped register");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_irq_masked: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !irq)
		else $error("irq while masked");
	a_irq_rise_unmasked: assert property ($rose(irq) |-> !$past(cpu_irq_mask))
		else $error("irq rose under mask");
	a_tx_idle_reset: assert property ($rose(presetn) |-> tx_pin)
		else $error("tx line not idle after reset");
	// Every bit lasts at least 16 pclk cycles, so a short low pulse is a divider slip
	a_bit_min_len: assert property ($fell(tx_pin) |-> (!tx_pin) [*8])
		else $error("tx low bit too short");
endmodule // sbp_serial_props

bind sbp_serial sbp_serial_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_pin(rx_pin), .cpu_irq_mask(cpu_irq_mask), .tx_pin(tx_pin), .irq(irq));

// *** bench/sbp_remote_node.sv ***
// Remote serial node: drives the receive line and captures words from the transmit line.
// Assumes its tasks are called right after a rising pclk edge, with the bit time in cycles.
`timescale 1ns/100ps
module sbp_remote_node (
	input wire logic pclk,
	input wire logic tx_pin,
	output logic rx_pin
);
	logic [8:0] got;
	initial rx_pin = 1'b1;
	// Stop level is the caller's so that a framing fault can be forced
	task automatic send(input logic [8:0] d, input int n, input int bt, input logic stop);
		for (int i = 0; i < n + 2; i++) begin
			rx_pin <= (i == 0) ? 1'b0 : (i > n) ? stop : d[i - 1];
			repeat (bt) @(posedge pclk);
		end
		// One idle bit keeps back-to-back frames apart and avoids a double drive in one step
		rx_pin <= 1'b1;
		repeat (bt) @(posedge pclk);
	endtask
	// Samples each data bit in the middle of its bit time
	task automatic recv(input int n, input int bt);
		got = 9'h000;
		while (tx_pin !== 1'b0) @(posedge pclk);
		repeat (bt / 2) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			repeat (bt) @(posedge pclk);
			got[i] = tx_pin;
		end
	endtask
endmodule // sbp_remote_node

// *** bench/testbench.sv ***
// Bench for the serial block: APB register tasks, a remote node and a scripted scenario run.
// Assumes the remote node model and the bound checker are compiled before it.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench import sbp_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, cpu_irq_mask, rx_pin, tx_pin, irq, pready, pslverr, err;
	logic [7:0] paddr, q;
	logic [31:0] pwdata, prdata;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int bt, want;
	int base[4] = '{1, 3, 4, 13};
	logic [15:0] cfg[7] = '{16'h0000, 16'h4800, 16'h9000, 16'hc000, 16'h1800, 16'h3800, 16'h0005};
	logic [24:0] fmt[4] = '{{8'h04, 8'hb5, 9'h035}, {8'h06, 8'h35, 9'h0b5}, {8'h50, 8'h3c, 9'h13c},
		{8'h14, 8'h07, 9'h107}};
	sbp_serial dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pin(rx_pin), .cpu_irq_mask(cpu_irq_mask), .tx_pin(tx_pin), .irq(irq));
	sbp_remote_node node_u (.pclk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// The slowest divider case dominates; the ceiling leaves it room twice over
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Status reads also arm the flag clear, so callers follow with the data access they intend
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			apb(1'b0, SBP_OFS_STATUS, 8'h00);
			k++;
		end while (q[b] !== 1'b1 && k < 30000);
		repeat (2) @(posedge pclk);
		`CHK("status flag", 1'b1, q[b])
	endtask
	task automatic txcfg(input logic [7:0] b, input logic [7:0] f);
		apb(1'b1, SBP_OFS_CTRL2, 8'h00);
		apb(1'b1, SBP_OFS_BAUD, b);
		apb(1'b1, SBP_OFS_TXFINE, f);
	endtask
	task automatic low_len(output int n);
		n = 0;
		while (tx_pin !== 1'b0) @(posedge pclk);
		while (tx_pin === 1'b0) begin
			@(posedge pclk);
			n++;
		end
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_irq_mask = 1'b1;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("status reset", SBP_STATUS_RST, q)
		apb(1'b0, SBP_OFS_RXFINE, 8'h00);
		`CHK("rx fine reset", 8'h00, q)
		apb(1'b0, 8'h40, 8'h00);
		`CHK("unmapped error", 1'b1, err)
		foreach (cfg[i]) begin
			txcfg(cfg[i][15:8], cfg[i][7:0]);
			apb(1'b1, SBP_OFS_CTRL2, 8'h08);
			apb(1'b0, SBP_OFS_STATUS, 8'h00);
			apb(1'b1, SBP_OFS_DATA, 8'hff);
			apb(1'b0, SBP_OFS_STATUS, 8'h00);
			`CHK("tx done cleared", 1'b0, q[6])
			low_len(bt);
			want = 16 * base[cfg[i][15:14]] * (1 << cfg[i][13:11]) * (cfg[i][7:0] == 0 ? 1 : cfg[i][7:0]);
			`CHK("tx bit time", want, bt)
			repeat (10 * want) @(posedge pclk);
			poll(SBP_BIT_TX_DONE);
		end
		txcfg(8'h00, 8'h00);
		foreach (fmt[i]) begin
			apb(1'b1, SBP_OFS_CTRL1, fmt[i][24:17]);
			apb(1'b1, SBP_OFS_CTRL2, 8'h08);
			apb(1'b0, SBP_OFS_STATUS, 8'h00);
			apb(1'b1, SBP_OFS_DATA, fmt[i][16:9]);
			node_u.recv(8 + fmt[i][21], 16);
			`CHK("tx word", fmt[i][8:0], node_u.got)
			repeat (32) @(posedge pclk);
			poll(SBP_BIT_TX_DONE);
			apb(1'b1, SBP_OFS_CTRL2, 8'h00);
		end
		apb(1'b1, SBP_OFS_CTRL1, 8'h20);
		apb(1'b1, SBP_OFS_CTRL2, 8'h08);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		apb(1'b1, SBP_OFS_DATA, 8'hff);
		repeat (400) @(posedge pclk);
		`CHK("low power hold", 1'b1, tx_pin)
		apb(1'b1, SBP_OFS_CTRL1, 8'h00);
		low_len(bt);
		`CHK("resumed bit time", 16, bt)
		repeat (200) @(posedge pclk);
		apb(1'b1, SBP_OFS_CTRL2, 8'h00);
		apb(1'b1, SBP_OFS_CTRL1, 8'h00);
		apb(1'b1, SBP_OFS_RXFINE, 8'h02);
		apb(1'b1, SBP_OFS_CTRL2, 8'h24);
		cpu_irq_mask <= 1'b0;
		node_u.send(9'h05a, 8, 32, 1'b1);
		poll(SBP_BIT_RX_FULL);
		`CHK("rx irq", 1'b1, irq)
		cpu_irq_mask <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		cpu_irq_mask <= 1'b0;
		apb(1'b0, SBP_OFS_DATA, 8'h00);
		`CHK("rx data", 8'h5a, q)
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("full cleared", 1'b0, q[5])
		`CHK("irq dropped", 1'b0, irq)
		node_u.send(9'h011, 8, 32, 1'b1);
		node_u.send(9'h022, 8, 32, 1'b0);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("overrun only", 3'b101, {q[3], q[1], irq})
		apb(1'b0, SBP_OFS_DATA, 8'h00);
		`CHK("held data", 8'h11, q)
		node_u.send(9'h044, 8, 32, 1'b0);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("frame fault", 2'b11, {q[5], q[1]})
		apb(1'b1, SBP_OFS_CTRL2, 8'h20);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("rx flags cleared", 5'h00, q[5:1])
		apb(1'b1, SBP_OFS_CTRL1, 8'h05);
		apb(1'b1, SBP_OFS_CTRL2, 8'h04);
		node_u.send(9'h0b5, 8, 32, 1'b1);
		poll(SBP_BIT_RX_FULL);
		`CHK("parity fail", 2'b11, {q[0], irq})
		apb(1'b0, SBP_OFS_DATA, 8'h00);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("parity cleared", 1'b0, q[0])
		apb(1'b1, SBP_OFS_CTRL1, 8'h08);
		apb(1'b1, SBP_OFS_CTRL2, 8'h26);
		node_u.send(9'h012, 8, 32, 1'b1);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("muted no flag", 2'b00, {q[5], irq})
		node_u.send(9'h092, 8, 32, 1'b1);
		poll(SBP_BIT_RX_FULL);
		apb(1'b0, SBP_OFS_DATA, 8'h00);
		`CHK("address word", 8'h92, q)
		apb(1'b0, SBP_OFS_CTRL2, 8'h00);
		`CHK("mute left", 1'b0, q[1])
		apb(1'b1, SBP_OFS_CTRL1, 8'h00);
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		apb(1'b0, SBP_OFS_DATA, 8'h00);
		apb(1'b1, SBP_OFS_CTRL2, 8'h06);
		node_u.send(9'h001, 8, 32, 1'b1);
		repeat (352) @(posedge pclk);
		apb(1'b0, SBP_OFS_CTRL2, 8'h00);
		`CHK("idle wake", 1'b0, q[1])
		apb(1'b0, SBP_OFS_STATUS, 8'h00);
		`CHK("no quiet on wake", 1'b0, q[4])
		wrap_up();
	end
endmodule // testbench
